// file: hdl/hcds_dist.sv
// Purpose: travelled-distance watcher from a latched origin
// Assumes: position wraps modulo 2**W, travel below 2**(W-1)
// Notes: distance is a magnitude, either direction counts
`timescale 1ns/10ps

module hcds_dist #(
  parameter int W = 32
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // control
  input wire logic start_i,
  input wire logic [W-1:0] cur_pos_i,
  input wire logic [W-1:0] dist_i,
  // result
  output logic reached_o
);

  typedef struct packed {
    logic [W-1:0] origin;
  } hcds_dist_st_t;

  hcds_dist_st_t st;
  hcds_dist_st_t next_st;
  logic [W-1:0] diff;
  logic [W-1:0] mag;

  always_comb begin
    next_st = st;
    if (start_i) begin
      next_st.origin = cur_pos_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign diff = cur_pos_i - st.origin;
  assign mag = diff[W-1] ? (~diff + W'(1)) : diff;
  assign reached_o = (mag >= dist_i);

endmodule : hcds_dist

// file: hdl/hcds_homing.sv
// Purpose: home return sequencer, count type and data set type
// Assumes: cur_pos_i and the Avalon-MM inputs come from logic on clk_i; controller inputs are pins
// Notes: Avalon-MM slave, one wait state on every access
//
// What this block does
// - Method type value 0 selects count type homing.
// - Method type value 2 selects data set type homing.
// - Count type: after dog front, travel post distance, then take Z.
// - Homing speed is commanded from start until the dog is seen.
// - Creep speed is commanded for all travel after the dog.
// - Home lies the shift distance beyond the first Z pulse after the post travel.
// - At completion the position is loaded with the home value.
// - Moves use acceleration and deceleration times of point one.
// - Data set homing is refused unless servo-on is active.
// - Data set homing takes the present position as home.
// - Dog polarity setting chooses which level means dog detected.
// - Travel direction comes from the same method setting.
//
// Our own choices: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`include "hcds_defs.svh"

module hcds_homing
  import hcds_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // avalon-mm slave
  input wire logic [`HCDS_ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // controller pins
  input wire logic op_mode_select_1_i,
  input wire logic [4:0] point_sel_bit_i,
  input wire logic fwd_start_in_i,
  input wire logic rev_start_in_i,
  input wire logic dog_i,
  input wire logic zphase_i,
  input wire logic servo_on_i,
  // position counter
  input wire logic [`HCDS_POS_W-1:0] cur_pos_i,
  output logic pos_load_o,
  output logic [`HCDS_POS_W-1:0] pos_load_value_o,
  // trajectory command
  output hcds_move_t move_o,
  // completion flags and interrupt
  output logic travel_done_flag_o,
  output logic rough_match_flag_o,
  output logic homing_done_flag_o,
  output logic irq_o
);

  // ==========================================================
  // declarations
  hcds_state_t st;
  hcds_state_t next_st;
  hcds_pins_t pins_raw;
  hcds_pins_t pins_s;
  logic home_mode;
  logic dog_det;
  logic dog_front;
  logic fwd_rise;
  logic rev_rise;
  logic start_any;
  logic z_rise;
  logic post_start;
  logic shift_start;
  logic post_reached;
  logic shift_reached;
  logic bus_req;
  logic bus_take;
  logic [`HCDS_ADDR_W-1:0] word_addr;
  logic [31:0] rd_mux;
  logic [`HCDS_EV_W-1:0] ev;
  logic [`HCDS_EV_W-1:0] ev_clr;

  function automatic logic [31:0] hcds_merge(input logic [31:0] old,
                                             input logic [31:0] wd,
                                             input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = wd[8*i +: 8];
      end
    end
    return r;
  endfunction : hcds_merge

  // ==========================================================
  // pin synchronisers and distance watchers
  assign pins_raw = {op_mode_select_1_i, point_sel_bit_i, fwd_start_in_i,
                     rev_start_in_i, dog_i, zphase_i, servo_on_i};

  hcds_sync #(
    .W($bits(hcds_pins_t))
  ) u_sync (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .d_i(pins_raw),
    .q_o(pins_s)
  );

  hcds_dist #(
    .W(`HCDS_POS_W)
  ) u_post (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .start_i(post_start),
    .cur_pos_i(cur_pos_i),
    .dist_i(st.cfg.post_travel),
    .reached_o(post_reached)
  );

  hcds_dist #(
    .W(`HCDS_POS_W)
  ) u_shift (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .start_i(shift_start),
    .cur_pos_i(cur_pos_i),
    .dist_i(st.cfg.home_shift),
    .reached_o(shift_reached)
  );

  // ==========================================================
  // input qualification
  assign home_mode = pins_s.mode && (pins_s.sel == 5'h00);
  assign dog_det = pins_s.dog ^ st.cfg.polarity;
  assign dog_front = dog_det && !st.dog_prev;
  assign fwd_rise = pins_s.fwd && !st.fwd_prev;
  assign rev_rise = pins_s.rev && !st.rev_prev;
  assign start_any = fwd_rise || rev_rise;
  assign z_rise = pins_s.zph && !st.z_prev;
  assign post_start = (st.phase == PH_FAST) && dog_front && home_mode;
  assign shift_start = (st.phase == PH_ZWAIT) && z_rise && home_mode;

  // ==========================================================
  // bus decode
  assign bus_req = avs_read_i || avs_write_i;
  assign bus_take = bus_req && st.ack;
  assign word_addr = {avs_address_i[`HCDS_ADDR_W-1:2], 2'h0};
  assign avs_waitrequest_o = bus_req && !st.ack;

  always_comb begin
    case (word_addr)
      `HCDS_OFS_METHOD: rd_mux = 32'(st.cfg.method);
      `HCDS_OFS_POLARITY: rd_mux = 32'(st.cfg.polarity);
      `HCDS_OFS_HOME_SPEED: rd_mux = 32'(st.cfg.home_speed);
      `HCDS_OFS_CREEP_SPEED: rd_mux = 32'(st.cfg.creep_speed);
      `HCDS_OFS_HOME_SHIFT: rd_mux = st.cfg.home_shift;
      `HCDS_OFS_HOME_POS: rd_mux = st.cfg.home_pos;
      `HCDS_OFS_POST_TRAVEL: rd_mux = st.cfg.post_travel;
      `HCDS_OFS_ACCDEC: rd_mux = {st.cfg.decel, st.cfg.accel};
      `HCDS_OFS_STATUS: rd_mux = 32'({st.phase, (st.phase != PH_IDLE),
                                       st.rough_match, st.travel_done,
                                       st.homing_done});
      `HCDS_OFS_INT_STATUS: rd_mux = 32'(st.int_status);
      `HCDS_OFS_INT_MASK: rd_mux = 32'(st.int_mask);
      `HCDS_OFS_CUR_POS: rd_mux = cur_pos_i;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  assign ev_clr = (avs_write_i && bus_take &&
                   word_addr == `HCDS_OFS_INT_STATUS && avs_byteenable_i[0])
                  ? avs_writedata_i[`HCDS_EV_W-1:0] : '0;

  // ==========================================================
  // next state
  always_comb begin
    next_st = st;
    ev = '0;
    next_st.pos_load = 1'b0;
    next_st.dog_prev = dog_det;
    next_st.fwd_prev = pins_s.fwd;
    next_st.rev_prev = pins_s.rev;
    next_st.z_prev = pins_s.zph;

    // a new motion drops the completion flags
    if (start_any) begin
      next_st.homing_done = 1'b0;
      next_st.travel_done = 1'b0;
      next_st.rough_match = 1'b0;
    end

    case (st.phase)
      PH_IDLE: begin
        if (start_any && home_mode) begin
          if (st.cfg.method[3:0] == `HCDS_METHOD_COUNT) begin
            next_st.phase = PH_FAST;
            next_st.move.en = 1'b1;
            next_st.move.dir = st.cfg.method[`HCDS_METHOD_DIR_BIT];
            next_st.move.speed = st.cfg.home_speed;
            next_st.move.accel = st.cfg.accel;
            next_st.move.decel = st.cfg.decel;
          end else if (st.cfg.method[3:0] == `HCDS_METHOD_DSET &&
                       pins_s.servo) begin
            // present position becomes home, no travel
            next_st.homing_done = 1'b1;
            next_st.travel_done = 1'b1;
            next_st.rough_match = 1'b1;
            next_st.pos_load = 1'b1;
            next_st.pos_load_value = st.cfg.home_pos;
            ev[`HCDS_EV_DONE] = 1'b1;
          end else begin
            // servo off, or a method this block does not run
            ev[`HCDS_EV_REFUSE] = 1'b1;
          end
        end
      end
      PH_FAST: begin
        if (dog_front) begin
          next_st.phase = PH_POST;
          next_st.move.speed = st.cfg.creep_speed;
          ev[`HCDS_EV_DOG] = 1'b1;
        end
      end
      PH_POST: begin
        if (post_reached) begin
          next_st.phase = PH_ZWAIT;
        end
      end
      PH_ZWAIT: begin
        if (z_rise) begin
          next_st.phase = PH_SHIFT;
        end
      end
      PH_SHIFT: begin
        if (shift_reached) begin
          next_st.phase = PH_IDLE;
          next_st.move.en = 1'b0;
          next_st.move.speed = '0;
          next_st.homing_done = 1'b1;
          next_st.travel_done = 1'b1;
          next_st.rough_match = 1'b1;
          next_st.pos_load = 1'b1;
          next_st.pos_load_value = st.cfg.home_pos;
          ev[`HCDS_EV_DONE] = 1'b1;
        end
      end
      default: begin
        next_st.phase = PH_IDLE;
        next_st.move.en = 1'b0;
      end
    endcase

    // leaving home mode mid-run stops the axis without completion unless shift_reached is set in that cycle
    if (st.phase != PH_IDLE && !home_mode) begin
      next_st.phase = PH_IDLE;
      next_st.move.en = 1'b0;
      next_st.move.speed = '0;
    end

    // bus: first cycle captures read data, second completes
    next_st.ack = bus_req && !st.ack;
    if (avs_read_i && !st.ack) begin
      next_st.readdata = rd_mux;
    end
    if (avs_write_i && bus_take) begin
      case (word_addr)
        `HCDS_OFS_METHOD: next_st.cfg.method = 8'(hcds_merge(
            32'(st.cfg.method), avs_writedata_i, avs_byteenable_i));
        `HCDS_OFS_POLARITY: begin
          if (avs_byteenable_i[0]) begin
            next_st.cfg.polarity = avs_writedata_i[0];
          end
        end
        `HCDS_OFS_HOME_SPEED: next_st.cfg.home_speed = 16'(hcds_merge(
            32'(st.cfg.home_speed), avs_writedata_i, avs_byteenable_i));
        `HCDS_OFS_CREEP_SPEED: next_st.cfg.creep_speed = 16'(hcds_merge(
            32'(st.cfg.creep_speed), avs_writedata_i, avs_byteenable_i));
        `HCDS_OFS_HOME_SHIFT: next_st.cfg.home_shift = hcds_merge(
            st.cfg.home_shift, avs_writedata_i, avs_byteenable_i);
        `HCDS_OFS_HOME_POS: next_st.cfg.home_pos = hcds_merge(
            st.cfg.home_pos, avs_writedata_i, avs_byteenable_i);
        `HCDS_OFS_POST_TRAVEL: next_st.cfg.post_travel = hcds_merge(
            st.cfg.post_travel, avs_writedata_i, avs_byteenable_i);
        `HCDS_OFS_ACCDEC: {next_st.cfg.decel, next_st.cfg.accel} =
            hcds_merge({st.cfg.decel, st.cfg.accel}, avs_writedata_i,
                       avs_byteenable_i);
        `HCDS_OFS_INT_MASK: begin
          if (avs_byteenable_i[0]) begin
            next_st.int_mask = avs_writedata_i[`HCDS_EV_W-1:0];
          end
        end
        default: begin
        end
      endcase
    end

    // a new event outranks a clear in the same cycle
    next_st.int_status = (st.int_status & ~ev_clr) | ev;
    next_st.irq = |(next_st.int_status & next_st.int_mask);
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      st <= '0;
      st.phase <= PH_IDLE;
      st.cfg.method <= `HCDS_METHOD_RST;
      st.cfg.polarity <= `HCDS_POLARITY_RST;
      st.cfg.home_speed <= `HCDS_SPEED_RST;
      st.cfg.creep_speed <= `HCDS_SPEED_RST;
      st.cfg.home_shift <= `HCDS_DIST_RST;
      st.cfg.home_pos <= `HCDS_DIST_RST;
      st.cfg.post_travel <= `HCDS_DIST_RST;
      st.cfg.accel <= `HCDS_TIME_RST;
      st.cfg.decel <= `HCDS_TIME_RST;
      st.int_mask <= `HCDS_MASK_RST;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================
  // outputs
  assign avs_readdata_o = st.readdata;
  assign pos_load_o = st.pos_load;
  assign pos_load_value_o = st.pos_load_value;
  assign move_o = st.move;
  assign travel_done_flag_o = st.travel_done;
  assign rough_match_flag_o = st.rough_match;
  assign homing_done_flag_o = st.homing_done;
  assign irq_o = st.irq;

  // ==========================================================
  // checks
  a_mode_gate: assert property (@(posedge clk_i) disable iff (reset_i)
    (st.phase == PH_IDLE && start_any && !home_mode)
      |=> (st.phase == PH_IDLE && !pos_load_o))
    else $error("start outside home mode was acted on");

  a_count_start: assert property (@(posedge clk_i) disable iff (reset_i)
    (st.phase == PH_IDLE && start_any && home_mode &&
     st.cfg.method[3:0] == 4'h0)
      |=> (st.phase == PH_FAST && move_o.en))
    else $error("count type start did not begin travel");

  a_dset_load: assert property (@(posedge clk_i) disable iff (reset_i)
    (st.phase == PH_IDLE && start_any && home_mode && pins_s.servo &&
     st.cfg.method[3:0] == 4'h2)
      |=> (pos_load_o && homing_done_flag_o && !move_o.en &&
           pos_load_value_o == $past(st.cfg.home_pos)))
    else $error("data set homing did not load home value");

  a_dset_refuse: assert property (@(posedge clk_i) disable iff (reset_i)
    (st.phase == PH_IDLE && start_any && home_mode && !pins_s.servo &&
     st.cfg.method[3:0] == 4'h2)
      |=> (!pos_load_o && !homing_done_flag_o &&
           st.int_status[`HCDS_EV_REFUSE]))
    else $error("data set homing accepted without servo-on");

  a_fast_speed: assert property (@(posedge clk_i) disable iff (reset_i)
    (st.phase == PH_FAST) |-> (move_o.speed == st.cfg.home_speed))
    else $error("wrong speed before dog");

  a_creep_speed: assert property (@(posedge clk_i) disable iff (reset_i)
    (st.phase inside {PH_POST, PH_ZWAIT, PH_SHIFT})
      |-> (move_o.speed == st.cfg.creep_speed && move_o.en))
    else $error("wrong speed after dog");

  a_dog_edge: assert property (@(posedge clk_i) disable iff (reset_i)
    (st.phase == PH_FAST && home_mode &&
     (pins_s.dog ^ st.cfg.polarity) && !$past(pins_s.dog ^ st.cfg.polarity))
      |=> (st.phase == PH_POST))
    else $error("dog front missed");

  a_z_take: assert property (@(posedge clk_i) disable iff (reset_i)
    (st.phase == PH_POST && !post_reached) |=> (st.phase != PH_ZWAIT))
    else $error("z accepted before post travel");

  a_shift_done: assert property (@(posedge clk_i) disable iff (reset_i)
    (st.phase == PH_SHIFT && shift_reached && home_mode)
      |=> (pos_load_o && pos_load_value_o == $past(st.cfg.home_pos))
          ##1 !pos_load_o)
    else $error("completion load wrong");

  a_flags_hold: assert property (@(posedge clk_i) disable iff (reset_i)
    (homing_done_flag_o && !start_any)
      |=> (homing_done_flag_o && travel_done_flag_o && rough_match_flag_o))
    else $error("completion flags dropped without new motion");

  a_accdec_dir: assert property (@(posedge clk_i) disable iff (reset_i)
    $rose(move_o.en) |-> (move_o.accel == st.cfg.accel &&
      move_o.decel == st.cfg.decel &&
      move_o.dir == st.cfg.method[`HCDS_METHOD_DIR_BIT]))
    else $error("move started with wrong time constants or direction");

endmodule : hcds_homing

// file: hdl/hcds_sync.sv
// Purpose: two-stage synchroniser for a bundle of pins
// Assumes: each bit is an independent level
// Notes: only the second stage leaves the module
`timescale 1ns/10ps

module hcds_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // pins
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } hcds_sync_st_t;

  hcds_sync_st_t st;
  hcds_sync_st_t next_st;

  always_comb begin
    next_st.s1 = d_i;
    next_st.s2 = st.s1;
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign q_o = st.s2;

endmodule : hcds_sync

// file: shared/hcds_defs.svh
// Purpose: offsets, field positions and reset values of the homing block
// Assumes: byte addresses on a 32-bit Avalon-MM slave, one word each
// Notes: definitions only
`ifndef HCDS_DEFS_SVH
`define HCDS_DEFS_SVH

// ==========================================================
// widths
`define HCDS_POS_W 32
`define HCDS_SPD_W 16
`define HCDS_ADDR_W 6
`define HCDS_EV_W 3

// ==========================================================
// register byte offsets
`define HCDS_OFS_METHOD 6'h00
`define HCDS_OFS_POLARITY 6'h04
`define HCDS_OFS_HOME_SPEED 6'h08
`define HCDS_OFS_CREEP_SPEED 6'h0C
`define HCDS_OFS_HOME_SHIFT 6'h10
`define HCDS_OFS_HOME_POS 6'h14
`define HCDS_OFS_POST_TRAVEL 6'h18
`define HCDS_OFS_ACCDEC 6'h1C
`define HCDS_OFS_STATUS 6'h20
`define HCDS_OFS_INT_STATUS 6'h24
`define HCDS_OFS_INT_MASK 6'h28
`define HCDS_OFS_CUR_POS 6'h2C

// ==========================================================
// method field: type in [3:0], travel direction bit
`define HCDS_METHOD_COUNT 4'h0
`define HCDS_METHOD_DSET 4'h2
`define HCDS_METHOD_DIR_BIT 4

// ==========================================================
// interrupt event bits
`define HCDS_EV_DONE 0
`define HCDS_EV_DOG 1
`define HCDS_EV_REFUSE 2

// ==========================================================
// reset values
`define HCDS_METHOD_RST 8'h00
`define HCDS_POLARITY_RST 1'h0
`define HCDS_SPEED_RST 16'h0000
`define HCDS_DIST_RST 32'h0000_0000
`define HCDS_TIME_RST 16'h0000
`define HCDS_MASK_RST 3'h0

`endif

// file: shared/hcds_pkg.sv
// Purpose: types shared by the homing sequencer files
// Assumes: hcds_defs.svh gives the widths
// Notes: none
`include "hcds_defs.svh"

package hcds_pkg;

  // ==========================================================
  // sequencer phases
  typedef enum logic [2:0] {
    PH_IDLE,
    PH_FAST,
    PH_POST,
    PH_ZWAIT,
    PH_SHIFT
  } hcds_phase_t;

  // ==========================================================
  // pin bundle, raw and synchronised
  typedef struct packed {
    logic mode;
    logic [4:0] sel;
    logic fwd;
    logic rev;
    logic dog;
    logic zph;
    logic servo;
  } hcds_pins_t;

  // command to the trajectory generator
  typedef struct packed {
    logic en;
    logic dir;
    logic [`HCDS_SPD_W-1:0] speed;
    logic [15:0] accel;
    logic [15:0] decel;
  } hcds_move_t;

  // software settings
  typedef struct packed {
    logic [7:0] method;
    logic polarity;
    logic [`HCDS_SPD_W-1:0] home_speed;
    logic [`HCDS_SPD_W-1:0] creep_speed;
    logic [`HCDS_POS_W-1:0] home_shift;
    logic [`HCDS_POS_W-1:0] home_pos;
    logic [`HCDS_POS_W-1:0] post_travel;
    logic [15:0] accel;
    logic [15:0] decel;
  } hcds_cfg_t;

  // all state of the sequencer
  typedef struct packed {
    hcds_cfg_t cfg;
    logic [`HCDS_EV_W-1:0] int_status;
    logic [`HCDS_EV_W-1:0] int_mask;
    hcds_phase_t phase;
    logic dog_prev;
    logic fwd_prev;
    logic rev_prev;
    logic z_prev;
    logic homing_done;
    logic travel_done;
    logic rough_match;
    hcds_move_t move;
    logic pos_load;
    logic [`HCDS_POS_W-1:0] pos_load_value;
    logic ack;
    logic [31:0] readdata;
    logic irq;
  } hcds_state_t;

endpackage : hcds_pkg

// file: sim/hcds_axis.sv
// Purpose: axis and sensor model facing the homing block
// Assumes: one count of travel per clock while moving
// Notes: dog and z derive from travel, not from time
`timescale 1ns/10ps

module hcds_axis
  import hcds_pkg::*;
#(
  parameter int DOG_AT = 40
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // from the block, and dog inversion from the bench
  input hcds_move_t move_i,
  input wire logic load_i,
  input wire logic [31:0] load_val_i,
  input wire logic dog_inv_i,
  // to the block
  output logic [31:0] pos_o,
  output logic dog_o,
  output logic z_o
);
  int trav;
  // ==========================================================
  // motion
  always_ff @(posedge clk_i) begin
    if (reset_i || !move_i.en) trav <= 0;
    else trav <= trav + 1;
    if (reset_i) pos_o <= 32'h0000_0003;
    else if (load_i) pos_o <= load_val_i;
    else if (move_i.en) pos_o <= move_i.dir ? pos_o - 32'h0000_0001
                                             : pos_o + 32'h0000_0001;
  end
  // dog held for the rest of the move, far past the minimum on-time
  assign dog_o = (trav >= DOG_AT) ^ dog_inv_i;
  assign z_o = move_i.en && (pos_o[3:0] == 4'h0);
endmodule : hcds_axis

// file: sim/hcds_homing_tb.sv
// Purpose: self-checking bench for the homing sequencer
// Assumes: one wait state per bus access
// Notes: hangs end through bounded waits
`timescale 1ns/10ps
`include "hcds_defs.svh"
`define CHK(nm, e, s) begin tests_run++; if ((s) !== (e)) begin \
  err_count++; $display("[ERR] %s exp %0h got %0h", nm, e, s); end end
`define WAIT(c) begin n = 0; while (!(c) && n < 2000) begin \
  @(negedge clk); n++; end if (n >= 2000) begin err_count++; \
  tally_and_finish(); end end

module hcds_homing_tb;
  import hcds_pkg::*;
  localparam logic [15:0] HSPD = 16'h0123;
  localparam logic [15:0] CSPD = 16'h0011;
  localparam logic [31:0] HPOS = 32'h0000_1000;
  logic clk = 0, rst = 1, rd = 0, wr = 0, mode = 0, fwd = 0, rev = 0;
  logic servo = 0, pol = 0, wq, load, dog, z, tdone, rough, hdone, irq;
  logic [5:0] adr = 0;
  logic [4:0] sel = 0;
  logic [31:0] wd = 0, rdo, rdat, pos, lval, p_load, zpos, p0;
  hcds_move_t mv;
  int err_count = 0, tests_run = 0, n;

  hcds_homing DUT (.clk_i(clk), .reset_i(rst), .avs_address_i(adr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
    .avs_byteenable_i(4'hf), .avs_readdata_o(rdo),
    .avs_waitrequest_o(wq), .op_mode_select_1_i(mode),
    .point_sel_bit_i(sel), .fwd_start_in_i(fwd), .rev_start_in_i(rev),
    .dog_i(dog), .zphase_i(z), .servo_on_i(servo), .cur_pos_i(pos),
    .pos_load_o(load), .pos_load_value_o(lval), .move_o(mv),
    .travel_done_flag_o(tdone), .rough_match_flag_o(rough),
    .homing_done_flag_o(hdone), .irq_o(irq));
  hcds_axis AX (.clk_i(clk), .reset_i(rst), .move_i(mv), .load_i(load),
    .load_val_i(lval), .dog_inv_i(pol), .pos_o(pos), .dog_o(dog), .z_o(z));

  initial begin
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    if (load) p_load <= pos;
    if (z) zpos <= pos;
  end

  // ==========================================================
  // helpers
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : tally_and_finish
  // request held until waitrequest is seen low, then released
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    adr <= a; wd <= d; wr <= w; rd <= !w;
    @(negedge clk);
    `WAIT(wq === 1'b0)
    @(posedge clk);
    // read data stand at the edge that completes the access
    rdat = rdo;
    wr <= 1'b0; rd <= 1'b0;
    @(posedge clk);
  endtask : bus
  task automatic kick(input logic r);
    if (r) rev <= 1'b1;
    else fwd <= 1'b1;
    repeat (6) @(posedge clk);
    fwd <= 1'b0; rev <= 1'b0;
    @(posedge clk);
  endtask : kick

  // ==========================================================
  // scenarios
  task automatic t_regs();
    bus(0, `HCDS_OFS_STATUS, 0); `CHK("status", 32'h0, rdat)
    bus(1, 6'h30, 32'h0000_5555);
    bus(0, 6'h30, 0); `CHK("unmapped", 32'h0, rdat)
    bus(1, `HCDS_OFS_HOME_SPEED, {16'h0, HSPD});
    bus(1, `HCDS_OFS_CREEP_SPEED, {16'h0, CSPD});
    bus(1, `HCDS_OFS_HOME_SHIFT, 32'h0000_0005);
    bus(1, `HCDS_OFS_POST_TRAVEL, 32'h0000_0014);
    bus(1, `HCDS_OFS_HOME_POS, HPOS);
    bus(1, `HCDS_OFS_ACCDEC, 32'h0007_0009);
    bus(1, `HCDS_OFS_INT_MASK, 32'h0000_0001);
    bus(0, `HCDS_OFS_ACCDEC, 0); `CHK("accdec", 32'h0007_0009, rdat)
  endtask : t_regs

  task automatic t_count(input logic p, input logic r);
    int dz;
    pol <= p;
    bus(1, `HCDS_OFS_POLARITY, {31'h0, p});
    bus(1, `HCDS_OFS_METHOD, r ? 32'h0000_0010 : 32'h0000_0000);
    mode <= 1'b1;
    p0 = pos;
    kick(r);
    `CHK("en", 1'b1, mv.en)
    `CHK("done_clr", 1'b0, hdone)
    `CHK("speed", HSPD, mv.speed)
    `CHK("dir", r, mv.dir)
    `CHK("accel", 16'h0009, mv.accel)
    `CHK("decel", 16'h0007, mv.decel)
    `WAIT(mv.speed === CSPD)
    `CHK("dog_seen", 1'b1, dog ^ p)
    `WAIT(hdone === 1'b1)
    // final position is captured on the edge that ends the load pulse, while load is still high
    @(negedge clk);
    `CHK("tdone", 1'b1, tdone)
    `CHK("rough", 1'b1, rough)
    `CHK("lval", HPOS, lval)
    `CHK("irq", 1'b1, irq)
    dz = $signed(p_load - zpos);
    if (dz < 0) dz = -dz;
    `CHK("shift", 1'b1, dz >= 5 && dz <= 13)
    dz = $signed(p_load - p0);
    if (dz < 0) dz = -dz;
    `CHK("travel", 1'b1, dz >= 65)
    repeat (5) @(negedge clk);
    `CHK("hold", 1'b1, hdone && !mv.en)
    `CHK("pos", HPOS, pos)
    bus(1, `HCDS_OFS_INT_STATUS, 32'h0000_0007);
    `CHK("irq_clr", 1'b0, irq)
  endtask : t_count

  task automatic t_dset();
    bus(1, `HCDS_OFS_METHOD, 32'h0000_0002);
    kick(0);
    `CHK("refused", 1'b0, hdone || mv.en)
    bus(0, `HCDS_OFS_INT_STATUS, 0); `CHK("int", 32'h4, rdat)
    `CHK("masked", 1'b0, irq)
    bus(1, `HCDS_OFS_INT_STATUS, 32'h0000_0004);
    bus(1, `HCDS_OFS_METHOD, 32'h0000_0000);
    sel <= 5'h01;
    kick(0);
    `CHK("no_mode", 1'b0, mv.en)
    sel <= 5'h00;
    servo <= 1'b1;
    bus(1, `HCDS_OFS_METHOD, 32'h0000_0002);
    bus(1, `HCDS_OFS_HOME_POS, 32'h0000_2222);
    kick(1);
    `CHK("ds_done", 3'h7, {hdone, tdone, rough})
    `CHK("ds_still", 1'b0, mv.en)
    `CHK("ds_pos", 32'h0000_2222, pos)
    bus(1, `HCDS_OFS_METHOD, 32'h0000_0003);
    kick(0);
    `CHK("bad_method", 3'h0, {hdone, mv.en, load})
    bus(1, `HCDS_OFS_METHOD, 32'h0000_0000);
    kick(0);
    `CHK("abort_run", 1'b1, mv.en)
    mode <= 1'b0;
    repeat (4) @(posedge clk);
    `CHK("abort", 2'h0, {mv.en, hdone})
  endtask : t_dset

  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_count(1'b0, 1'b0);
    t_count(1'b1, 1'b1);
    t_dset();
    tally_and_finish();
  end
endmodule : hcds_homing_tb
